// ---- core/keepalive_timer.sv ----
`timescale 1ns/100ps
module keepalive_timer #(
  parameter longint unit_cycles = sock_rx_pkg::keepalive_unit_cycles
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic enable_i,
  input wire logic [7:0] interval_i,
  input wire logic manual_i,
  // Result
  output logic peer_probe_o
);

  if (unit_cycles < 1 || unit_cycles > 64'h0000_00ff_ffff_ffff)
  begin : g_bad_unit
    $error("unit_cycles must fit the forty-bit unit counter");
  end

  logic [39:0] unit_count;
  logic [7:0] unit_total;
  logic unit_tick;
  logic period_done;
  logic auto_mode;

  assign auto_mode = (interval_i != 8'h00);
  assign unit_tick = (unit_count == 40'(unit_cycles - 1));
  assign period_done = unit_tick && ((unit_total + 8'h01) >= interval_i);

  // ----------------------------------------
  // Interval counting
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      unit_count <= 40'h0;
      unit_total <= 8'h00;
    end
    else if (!enable_i || !auto_mode || period_done)
    begin
      unit_count <= 40'h0;
      unit_total <= 8'h00;
    end
    else if (unit_tick)
    begin
      unit_count <= 40'h0;
      unit_total <= unit_total + 8'h01;
    end
    else
    begin
      unit_count <= unit_count + 40'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      peer_probe_o <= 1'b0;
    end
    else
    begin
      peer_probe_o <= enable_i && (auto_mode ? period_done : manual_i);
    end
  end

endmodule : keepalive_timer

// ---- core/socket_rx_pointer_regs.sv ----
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
module socket_rx_pointer_regs #(
  parameter longint keepalive_cycles = sock_rx_pkg::keepalive_unit_cycles,
  parameter int socket_index = 0
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Protocol engine side
  input wire logic [15:0] rx_stored_bytes_i,
  input wire logic rx_stored_valid_i,
  input wire logic [4:0] event_pulse_i,
  input wire logic session_up_i,
  input wire logic tcp_mode_i,
  input wire logic [7:0] global_event_flags_i,
  output logic [15:0] ip_fragment_field_o,
  output logic [15:0] rx_write_pointer_o,
  output logic peer_probe_o,
  output logic send_cmd_o,
  // Host interrupt pin
  output logic host_irq_low_o
);

  if (socket_index < 0 || socket_index > 7)
  begin : g_bad_index
    $error("socket_index must be 0 to 7");
  end
  if (keepalive_cycles < 1 || keepalive_cycles > 64'h0000_00ff_ffff_ffff)
  begin : g_bad_cycles
    $error("keepalive_cycles must fit the forty-bit unit counter");
  end

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [15:0] bytes_of_kb(input logic [4:0] kb);
    begin
      bytes_of_kb = {1'b0, kb, 10'h000};
    end
  endfunction : bytes_of_kb

  function automatic logic size_legal(input logic [7:0] kb);
    begin
      size_legal = (kb == 8'h00) || (kb == 8'h01) || (kb == 8'h02) || (kb == 8'h04) ||
        (kb == 8'h08) || (kb == 8'h10);
    end
  endfunction : size_legal

  function automatic logic addr_is(input logic [31:0] a, input logic [7:0] idx);
    begin
      addr_is = (a[31:2] == {22'h0, idx});
    end
  endfunction : addr_is

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  logic wr_pend;
  logic [31:0] wr_addr;
  logic rd_take;
  logic wr_take;
  assign rd_take = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  assign wr_take = hsel_i && hready_i && htrans_i[1] && hwrite_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0;
    end
    else
    begin
      wr_pend <= wr_take;
      wr_addr <= haddr_i;
    end
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  logic we_capacity;
  logic we_read_ptr;
  logic we_mask;
  logic we_frag;
  logic we_kpalv;
  logic we_cmd;
  logic we_flags;
  assign we_capacity = wr_pend && addr_is(wr_addr, sock_rx_pkg::idx_rx_buffer_capacity);
  assign we_read_ptr = wr_pend && addr_is(wr_addr, sock_rx_pkg::idx_rx_read_pointer);
  assign we_mask = wr_pend && addr_is(wr_addr, sock_rx_pkg::idx_socket_event_mask);
  assign we_frag = wr_pend && addr_is(wr_addr, sock_rx_pkg::idx_ip_fragment_field);
  assign we_kpalv = wr_pend && addr_is(wr_addr, sock_rx_pkg::idx_keepalive_interval);
  assign we_cmd = wr_pend && addr_is(wr_addr, sock_rx_pkg::idx_command);
  assign we_flags = wr_pend && addr_is(wr_addr, sock_rx_pkg::idx_socket_event_flags);

  logic cmd_open_hit;
  logic cmd_receive_done_cmd_hit;
  logic cmd_send_hit;
  logic cmd_ka_hit;
  assign cmd_open_hit = we_cmd && (hwdata_i[2:0] == sock_rx_pkg::cmd_open);
  assign cmd_receive_done_cmd_hit = we_cmd && (hwdata_i[2:0] == sock_rx_pkg::cmd_receive_done);
  assign cmd_send_hit = we_cmd && (hwdata_i[2:0] == sock_rx_pkg::cmd_send);
  assign cmd_ka_hit = we_cmd && (hwdata_i[2:0] == sock_rx_pkg::cmd_keepalive);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [4:0] rx_buffer_capacity;
  logic [15:0] rx_read_pointer;
  logic [15:0] rx_read_committed;
  logic [15:0] rx_write_pointer;
  logic [7:0] socket_event_mask;
  logic [15:0] ip_fragment_field;
  logic [7:0] keepalive_interval;
  logic [4:0] socket_event_flags;
  logic traffic_seen;
  logic [15:0] rx_received_size;

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_buffer_capacity <= sock_rx_pkg::rst_rx_buffer_capacity;
      socket_event_mask <= sock_rx_pkg::rst_socket_event_mask;
      ip_fragment_field <= sock_rx_pkg::rst_ip_fragment_field;
      keepalive_interval <= sock_rx_pkg::rst_keepalive_interval;
    end
    else
    begin
      if (we_capacity && size_legal(hwdata_i[7:0]))
      begin
        rx_buffer_capacity <= hwdata_i[4:0];
      end
      if (we_mask)
      begin
        socket_event_mask <= {3'h0, hwdata_i[4:0]};
      end
      if (we_frag)
      begin
        ip_fragment_field <= hwdata_i[15:0];
      end
      if (we_kpalv)
      begin
        keepalive_interval <= hwdata_i[7:0];
      end
    end
  end

  // ----------------------------------------
  // Receive pointers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_read_pointer <= sock_rx_pkg::rst_rx_read_pointer;
      rx_read_committed <= sock_rx_pkg::rst_rx_read_pointer;
      rx_write_pointer <= sock_rx_pkg::rst_rx_write_pointer;
    end
    else if (cmd_open_hit)
    begin
      rx_read_pointer <= sock_rx_pkg::rst_rx_read_pointer;
      rx_read_committed <= sock_rx_pkg::rst_rx_read_pointer;
      rx_write_pointer <= sock_rx_pkg::rst_rx_write_pointer;
    end
    else
    begin
      if (we_read_ptr)
      begin
        rx_read_pointer <= hwdata_i[15:0];
      end
      if (cmd_receive_done_cmd_hit)
      begin
        rx_read_committed <= rx_read_pointer;
      end
      if (rx_stored_valid_i)
      begin
        rx_write_pointer <= rx_write_pointer + rx_stored_bytes_i;
      end
    end
  end

  logic [15:0] raw_size;
  logic [15:0] cap_bytes;
  assign raw_size = rx_write_pointer - rx_read_committed;
  assign cap_bytes = bytes_of_kb(rx_buffer_capacity);
  assign rx_received_size = (raw_size > cap_bytes) ? cap_bytes : raw_size;

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  logic [4:0] flag_set;
  assign flag_set = event_pulse_i & socket_event_mask[4:0];

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      socket_event_flags <= 5'h00;
      traffic_seen <= 1'b0;
      host_irq_low_o <= 1'b1;
    end
    else
    begin
      socket_event_flags <= (socket_event_flags & ~(we_flags ? hwdata_i[4:0] : 5'h00))
        | flag_set;
      if (cmd_open_hit)
      begin
        traffic_seen <= 1'b0;
      end
      else if (rx_stored_valid_i || event_pulse_i[sock_rx_pkg::ev_tx_done])
      begin
        traffic_seen <= 1'b1;
      end
      host_irq_low_o <= !(|(socket_event_flags & socket_event_mask[4:0])
        && global_event_flags_i[socket_index]);
    end
  end

  // ----------------------------------------
  // Keep-alive
  // ----------------------------------------
  logic ka_enable;
  logic probe;
  assign ka_enable = tcp_mode_i && session_up_i && traffic_seen;

  keepalive_timer #(
    .unit_cycles(keepalive_cycles)
  ) u_keepalive (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .enable_i(ka_enable),
    .interval_i(keepalive_interval),
    .manual_i(cmd_ka_hit),
    .peer_probe_o(probe)
  );

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      send_cmd_o <= 1'b0;
    end
    else
    begin
      send_cmd_o <= cmd_send_hit;
    end
  end

  assign peer_probe_o = probe;
  assign ip_fragment_field_o = ip_fragment_field;
  assign rx_write_pointer_o = rx_write_pointer;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rd_mux;
  logic [7:0] status_bits;
  assign status_bits = {5'h00, tcp_mode_i, traffic_seen, session_up_i};
  always_comb
  begin
    rd_mux = 32'h0;
    if (addr_is(haddr_i, sock_rx_pkg::idx_rx_buffer_capacity))
    begin
      rd_mux = {27'h0, rx_buffer_capacity};
    end
    else if (addr_is(haddr_i, sock_rx_pkg::idx_rx_received_size))
    begin
      rd_mux = {16'h0, rx_received_size};
    end
    else if (addr_is(haddr_i, sock_rx_pkg::idx_rx_read_pointer))
    begin
      rd_mux = {16'h0, rx_read_pointer};
    end
    else if (addr_is(haddr_i, sock_rx_pkg::idx_rx_write_pointer))
    begin
      rd_mux = {16'h0, rx_write_pointer};
    end
    else if (addr_is(haddr_i, sock_rx_pkg::idx_socket_event_mask))
    begin
      rd_mux = {24'h0, socket_event_mask};
    end
    else if (addr_is(haddr_i, sock_rx_pkg::idx_ip_fragment_field))
    begin
      rd_mux = {16'h0, ip_fragment_field};
    end
    else if (addr_is(haddr_i, sock_rx_pkg::idx_keepalive_interval))
    begin
      rd_mux = {24'h0, keepalive_interval};
    end
    else if (addr_is(haddr_i, sock_rx_pkg::idx_socket_event_flags))
    begin
      rd_mux = {27'h0, socket_event_flags};
    end
    else if (addr_is(haddr_i, sock_rx_pkg::idx_status))
    begin
      rd_mux = {24'h0, status_bits};
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hrdata_o <= 32'h0;
    end
    else if (rd_take)
    begin
      hrdata_o <= rd_mux;
    end
  end

endmodule : socket_rx_pointer_regs

// ---- pkg/sock_rx_pkg.sv ----
package sock_rx_pkg;

  // ----------------------------------------
  // Register indices (word indices; byte offset is four times the index)
  // ----------------------------------------
  localparam logic [7:0] idx_rx_buffer_capacity = 8'h1e;
  localparam logic [7:0] idx_rx_received_size = 8'h26;
  localparam logic [7:0] idx_rx_read_pointer = 8'h28;
  localparam logic [7:0] idx_rx_write_pointer = 8'h2a;
  localparam logic [7:0] idx_socket_event_mask = 8'h2c;
  localparam logic [7:0] idx_ip_fragment_field = 8'h2d;
  localparam logic [7:0] idx_keepalive_interval = 8'h2f;
  localparam logic [7:0] idx_command = 8'h30;
  localparam logic [7:0] idx_socket_event_flags = 8'h31;
  localparam logic [7:0] idx_status = 8'h32;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] rst_rx_read_pointer = 16'h0000;
  localparam logic [15:0] rst_rx_write_pointer = 16'h0000;
  localparam logic [7:0] rst_socket_event_mask = 8'hff;
  localparam logic [15:0] rst_ip_fragment_field = 16'h4000;
  localparam logic [7:0] rst_keepalive_interval = 8'h00;
  localparam logic [4:0] rst_rx_buffer_capacity = 5'h02;

  // ----------------------------------------
  // Event bit positions
  // ----------------------------------------
  localparam int ev_session_made = 0;
  localparam int ev_session_closed = 1;
  localparam int ev_rx_arrived = 2;
  localparam int ev_timeout = 3;
  localparam int ev_tx_done = 4;
  localparam int ev_width = 5;

  // ----------------------------------------
  // Command codes and status bits
  // ----------------------------------------
  localparam logic [2:0] cmd_open = 3'h1;
  localparam logic [2:0] cmd_receive_done = 3'h2;
  localparam logic [2:0] cmd_send = 3'h3;
  localparam logic [2:0] cmd_keepalive = 3'h4;
  localparam int st_session_up = 0;
  localparam int st_traffic_seen = 1;
  localparam int st_tcp_mode = 2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint keepalive_unit_s = 5;
  localparam longint clk_hz = 250000000;
  localparam longint keepalive_unit_cycles = keepalive_unit_s * clk_hz;

endpackage : sock_rx_pkg

// ---- tb/host_bus_model.sv ----
`timescale 1ns/100ps
module host_bus_model
(
  // Clock and bus answer
  input wire logic sys_clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  // Bus request
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  initial
  begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
  end

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge sys_clk_i);
    hsel_o <= 1'b1;
    haddr_o <= a;
    htrans_o <= 2'h2;
    hwrite_o <= w;
    @(posedge sys_clk_i);
    while (hready_i !== 1'b1) @(posedge sys_clk_i);
    htrans_o <= 2'h0;
    hwdata_o <= d;
    @(posedge sys_clk_i);
    while (hready_i !== 1'b1) @(posedge sys_clk_i);
    q = hrdata_i;
    hsel_o <= 1'b0;
    haddr_o <= ~a;
    hwdata_o <= ~d;
  endtask : xfer

  task automatic rd16(input logic [31:0] a, output logic [31:0] q);
    logic [31:0] p;
    xfer(1'b0, a, 32'h0, p);
    xfer(1'b0, a, 32'h0, q);
    while (q !== p)
    begin
      p = q;
      xfer(1'b0, a, 32'h0, q);
    end
  endtask : rd16

  task automatic consume(input logic [15:0] n);
    logic [31:0] p;
    logic [31:0] q;
    rd16(32'ha0, p);
    xfer(1'b1, 32'ha0, {16'h0, p[15:0] + n}, q);
    xfer(1'b1, 32'hc0, {29'h0, sock_rx_pkg::cmd_receive_done}, q);
  endtask : consume

  task automatic send();
    logic [31:0] q;
    xfer(1'b1, 32'hc0, {29'h0, sock_rx_pkg::cmd_send}, q);
  endtask : send
endmodule : host_bus_model

// ---- tb/socket_rx_pointer_regs_checker.sv ----
`timescale 1ns/100ps
module socket_rx_pointer_regs_checker #(
  parameter int socket_index = 0
)
(
  // Watched ports
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [15:0] rx_stored_bytes_i,
  input wire logic rx_stored_valid_i,
  input wire logic session_up_i,
  input wire logic tcp_mode_i,
  input wire logic [7:0] global_event_flags_i,
  input wire logic [15:0] ip_fragment_field_o,
  input wire logic [15:0] rx_write_pointer_o,
  input wire logic peer_probe_o,
  input wire logic send_cmd_o,
  input wire logic host_irq_low_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic wr_dphase;
  always_ff @(posedge sys_clk_i or negedge nrst_i)
    if (!nrst_i)
      wr_dphase <= 1'b0;
    else
      wr_dphase <= hsel_i & hready_i & htrans_i[1] & hwrite_i;

  wptr_adv_a: assert property (rx_stored_valid_i && !wr_dphase |=>
    rx_write_pointer_o == $past(rx_write_pointer_o) + $past(rx_stored_bytes_i))
    else $error("write pointer did not advance by stored bytes");
  wptr_hold_a: assert property (!rx_stored_valid_i && !wr_dphase |=>
    $stable(rx_write_pointer_o)) else $error("write pointer moved without data");
  irq_global_a: assert property (!global_event_flags_i[socket_index] |=>
    host_irq_low_o) else $error("interrupt low without global bit");
  probe_gate_a: assert property (peer_probe_o |->
    $past(session_up_i) && $past(tcp_mode_i)) else $error("probe outside tcp session");
  probe_pulse_a: assert property (peer_probe_o |=> !peer_probe_o)
    else $error("probe longer than one cycle");
  send_pulse_a: assert property (send_cmd_o |=> !send_cmd_o)
    else $error("send longer than one cycle");
  frag_hold_a: assert property (!wr_dphase |=> $stable(ip_fragment_field_o))
    else $error("fragment field changed without write");
  rdata_hold_a: assert property (!(hsel_i && hready_i && htrans_i[1] && !hwrite_i)
    |=> $stable(hrdata_o)) else $error("read data changed without read");
  okay_resp_a: assert property (hreadyout_o && !hresp_o) else $error("bad bus response");
  cover property (peer_probe_o);
  cover property (!host_irq_low_o);
  cover property (send_cmd_o);
endmodule : socket_rx_pointer_regs_checker

bind socket_rx_pointer_regs socket_rx_pointer_regs_checker #(.socket_index(socket_index))
  i_socket_rx_pointer_regs_checker (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .rx_stored_bytes_i(rx_stored_bytes_i), .rx_stored_valid_i(rx_stored_valid_i),
  .session_up_i(session_up_i), .tcp_mode_i(tcp_mode_i),
  .global_event_flags_i(global_event_flags_i), .ip_fragment_field_o(ip_fragment_field_o),
  .rx_write_pointer_o(rx_write_pointer_o), .peer_probe_o(peer_probe_o),
  .send_cmd_o(send_cmd_o), .host_irq_low_o(host_irq_low_o));

// ---- tb/socket_rx_pointer_regs_tb_top.sv ----
`timescale 1ns/100ps
module socket_rx_pointer_regs_tb_top;
  logic clk, nrst, hsel, hwrite, hready, hresp, valid, sess, tcp, probe, sendc, irq_n;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] nbytes, frag, wptr;
  logic [4:0] ev;
  logic [7:0] gflags;
  int miscompares = 0, tests_run = 0, probes = 0, sends = 0, n;

  socket_rx_pointer_regs #(.keepalive_cycles(10), .socket_index(0)) i_socket_rx_pointer_regs (
    .sys_clk_i(clk), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .rx_stored_bytes_i(nbytes),
    .rx_stored_valid_i(valid), .event_pulse_i(ev), .session_up_i(sess), .tcp_mode_i(tcp),
    .global_event_flags_i(gflags), .ip_fragment_field_o(frag), .rx_write_pointer_o(wptr),
    .peer_probe_o(probe), .send_cmd_o(sendc), .host_irq_low_o(irq_n));
  host_bus_model i_host_bus_model (.sys_clk_i(clk), .hready_i(hready), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    probes <= probes + ((probe === 1'b1) ? 1 : 0);
    sends <= sends + ((sendc === 1'b1) ? 1 : 0);
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_host_bus_model.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
    i_host_bus_model.rd16(a, q);
    chk(nm, q, e);
  endtask : rdc
  task automatic store(input logic [15:0] b);
    @(posedge clk);
    valid <= 1'b1;
    nbytes <= b;
    @(posedge clk);
    valid <= 1'b0;
    nbytes <= 16'h0;
  endtask : store
  task automatic pulse(input logic [4:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 5'h0;
  endtask : pulse
  task automatic window(output int c);
    int p;
    p = probes;
    repeat (40) @(posedge clk);
    c = probes - p;
  endtask : window

  task automatic t_regs();
    rdc("size", 32'h98, 32'h0);
    rdc("rdptr", 32'ha0, 32'h0);
    rdc("wrptr", 32'ha8, 32'h0);
    rdc("mask", 32'hb0, 32'hff);
    rdc("frag", 32'hb4, 32'h4000);
    rdc("kpal", 32'hbc, 32'h0);
    wr(32'h78, 32'h3);
    rdc("cap bad", 32'h78, 32'h2);
    wr(32'h78, 32'h10);
    rdc("cap 16", 32'h78, 32'h10);
    wr(32'h78, 32'h2);
    wr(32'hb4, 32'h0);
    @(posedge clk);
    chk("frag out", {16'h0, frag}, 32'h0);
    wr(32'ha8, 32'h1234);
    rdc("wrptr ro", 32'ha8, 32'h0);
    rdc("unmapped", 32'hfc, 32'h0);
  endtask : t_regs

  task automatic t_rx();
    wr(32'hc0, {29'h0, sock_rx_pkg::cmd_open});
    store(16'h100);
    rdc("size", 32'h98, 32'h100);
    i_host_bus_model.consume(16'h40);
    rdc("size done", 32'h98, 32'hc0);
    store(16'h800);
    rdc("size cap", 32'h98, 32'h800);
    wr(32'hc0, {29'h0, sock_rx_pkg::cmd_open});
    rdc("rdptr open", 32'ha0, 32'h0);
    chk("wrptr open", {16'h0, wptr}, 32'h0);
    store(16'hfff0);
    i_host_bus_model.consume(16'hfff0);
    store(16'h20);
    @(posedge clk);
    chk("wrptr wrap", {16'h0, wptr}, 32'h10);
    rdc("size wrap", 32'h98, 32'h20);
    i_host_bus_model.consume(16'h20);
    rdc("rdptr wrap", 32'ha0, 32'h10);
    rdc("size empty", 32'h98, 32'h0);
  endtask : t_rx

  task automatic t_irq();
    for (int b = 0; b < 5; b++)
    begin
      wr(32'hb0, 32'h1 << b);
      pulse(5'h1 << ((b + 1) % 5));
      rdc("flag masked", 32'hc4, 32'h0);
      pulse(5'h1 << b);
      rdc("flag set", 32'hc4, 32'h1 << b);
      chk("irq low", {31'h0, irq_n}, 32'h0);
      wr(32'hc4, 32'h1 << b);
      repeat (2) @(posedge clk);
      chk("irq high", {31'h0, irq_n}, 32'h1);
    end
    gflags <= 8'h00;
    pulse(5'h10);
    repeat (2) @(posedge clk);
    chk("irq global", {31'h0, irq_n}, 32'h1);
    gflags <= 8'h01;
    repeat (2) @(posedge clk);
    chk("irq global on", {31'h0, irq_n}, 32'h0);
    wr(32'hc4, 32'h1f);
  endtask : t_irq

  task automatic t_ka();
    int p;
    tcp <= 1'b1;
    sess <= 1'b1;
    p = probes;
    wr(32'hc0, {29'h0, sock_rx_pkg::cmd_keepalive});
    repeat (3) @(posedge clk);
    chk("manual probe", probes - p, 1);
    wr(32'hbc, 32'h2);
    repeat (25) @(posedge clk);
    p = probes;
    wr(32'hc0, {29'h0, sock_rx_pkg::cmd_keepalive});
    repeat (37) @(posedge clk);
    chk("auto probes", probes - p, 2);
    tcp <= 1'b0;
    window(n);
    chk("no tcp", n, 0);
    tcp <= 1'b1;
    sess <= 1'b0;
    window(n);
    chk("no session", n, 0);
    sess <= 1'b1;
    wr(32'hc0, {29'h0, sock_rx_pkg::cmd_open});
    window(n);
    chk("no traffic", n, 0);
    store(16'h1);
    window(n);
    chk("first period", n, 1);
    rdc("status", 32'hc8, 32'h7);
    p = sends;
    i_host_bus_model.send();
    repeat (2) @(posedge clk);
    chk("send", sends - p, 1);
  endtask : t_ka

  task automatic end_of_test();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  initial
  begin
    #200000;
    miscompares++;
    end_of_test();
  end
  initial
  begin
    {nrst, valid, sess, tcp, ev, nbytes} = '0;
    gflags = 8'h01;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_rx();
    t_irq();
    t_ka();
    end_of_test();
  end
endmodule : socket_rx_pointer_regs_tb_top
